// ---- bench/host_model.sv ----
// Host management controller model that drives the byte register port
`timescale 1ns/1ps

module host_model (
  input wire logic sys_clk,
  input wire xcvr_diag_pkg::byte_t reg_rdata,
  output logic [7:0] reg_addr,
  output xcvr_diag_pkg::byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  import xcvr_diag_pkg::*;

  // Bus idle from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; released lines flip so stale values never look valid
  task automatic wr_byte(input logic [7:0] a, input byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe, so take them there
  task automatic rd_byte(input logic [7:0] a, output byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // host_model

// ---- bench/tb.sv ----
// Self-checking bench for the diagnostic control map
`timescale 1ns/1ps
`include "xcvr_diag_consts.svh"

module tb;
  import xcvr_diag_pkg::*;
  localparam logic [7:0] CSUM = 8'hA5; // Arbitrary checksum value
  localparam logic [7:0] CALV = 8'h3C; // Arbitrary calibration filler
  // Clock, reset and bus
  logic sys_clk, rst_n, ce, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  byte_t reg_wdata, reg_rdata;
  // Pins and internal levels
  logic tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_int, rx_los_int, mon_valid;
  mon_arr_t mon_value, thr_alarm_hi, thr_alarm_lo, thr_warn_hi, thr_warn_lo;
  logic tx_disable, tx_fault, rx_los, rx_rate_full, tx_rate_full;
  int n_fail, total_checks;
  logic [3:0] j;
  // Fixed bytes: reserved, calibration ends, checksum, unmapped
  logic [7:0] fa [6] = '{8'h37, 8'h38, 8'h5E, 8'h5F, 8'h6F, 8'h77};
  logic [7:0] fe [6] = '{8'h00, CALV, CALV, CSUM, 8'h00, 8'h00};
  // All five outputs packed for one compare
  wire logic [7:0] outs = {3'h0, tx_disable, tx_fault, rx_los, rx_rate_full, tx_rate_full};

  transceiver_diag_control_map #(.CHECKSUM(CSUM), .CAL_DEFAULT(CALV))
    u_transceiver_diag_control_map (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_disable_pin(tx_disable_pin), .rx_rate_pin(rx_rate_pin), .tx_rate_pin(tx_rate_pin),
    .tx_fault_int(tx_fault_int), .rx_los_int(rx_los_int), .mon_valid(mon_valid),
    .mon_value(mon_value), .thr_alarm_hi(thr_alarm_hi), .thr_alarm_lo(thr_alarm_lo),
    .thr_warn_hi(thr_warn_hi), .thr_warn_lo(thr_warn_lo), .tx_disable(tx_disable),
    .tx_fault(tx_fault), .rx_los(rx_los), .rx_rate_full(rx_rate_full),
    .tx_rate_full(tx_rate_full));

  host_model u_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  // Wait whole cycles, then step past the edge so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input byte_t d);
    u_host_model.wr_byte(a, d);
  endtask

  // Read one byte and compare
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    byte_t d;
    u_host_model.rd_byte(a, d);
    chk(nm, exp, d);
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, more than ten times the expected run length
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    {tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_int, rx_los_int, mon_valid} = 6'h00;
    mon_value = '0;
    thr_alarm_hi = '0;
    thr_alarm_lo = '0;
    thr_warn_hi = '0;
    thr_warn_lo = '0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(4);
    // Idle state: not ready, every output low, read data back to zero
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'h01);
    wt(1);
    chk("rdata_idle", 8'h00, reg_rdata);
    chk("outs", 8'h00, outs);
    $display("reset test done");
    // Soft bits only take; pin and status bits ignore writes
    wr(`OFS_SOFT_CTRL, 8'hFF);
    wt(2);
    chk("outs", 8'h12, outs);
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'h49);
    wr(`OFS_SOFT_CTRL, 8'h00);
    $display("soft test done");
    // Pin levels and status mirrored into byte and outputs
    @(posedge sys_clk);
    {tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_int, rx_los_int, mon_valid} <= 6'h3F;
    wt(4);
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'hB6);
    chk("outs", 8'h1F, outs);
    @(posedge sys_clk);
    {tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_int, rx_los_int} <= 5'h00;
    wt(4);
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'h00);
    chk("outs", 8'h00, outs);
    $display("pin test done");
    // Every rate pin and soft rate bit combination, both directions at once
    for (int k = 0; k < 16; k++) begin
      j = k[3:0];
      @(posedge sys_clk);
      rx_rate_pin <= j[0];
      tx_rate_pin <= j[2];
      wr(`OFS_SOFT_CTRL, {4'h0, j[1], 3'h0});
      wr(`OFS_EXT_CTRL, {4'h0, j[3], 3'h0});
      wt(4);
      chk("rates", {6'h00, j[0] | j[1], j[2] | j[3]}, {6'h00, rx_rate_full, tx_rate_full});
      rdc("soft_ctrl", `OFS_SOFT_CTRL, {2'h0, j[2], j[0], j[1], 3'h0});
      rdc("ext_ctrl", `OFS_EXT_CTRL, {4'h0, j[3], 3'h0});
    end
    $display("rate test done");
    // Power class stays inactive whatever is written
    wr(`OFS_EXT_CTRL, 8'hFF);
    rdc("ext_ctrl", `OFS_EXT_CTRL, 8'h08);
    wr(`OFS_EXT_CTRL, 8'h00);
    wr(`OFS_CHECKSUM, 8'h00);
    foreach (fa[i]) rdc("fixed", fa[i], fe[i]);
    $display("fixed byte test done");
    // Monitor words: -1.5 C, 3.3 V, 12 mA, 1 mW, 0.3 mW
    @(posedge sys_clk);
    mon_value <= {16'h0BB8, 16'h2710, 16'h1770, 16'h80E8, 16'hFE80};
    thr_alarm_hi <= {5{16'h2000}};
    thr_alarm_lo <= {5{16'h1000}};
    thr_warn_hi <= {5{16'h1700}};
    thr_warn_lo <= {5{16'h1400}};
    wt(3);
    for (int c = 0; c < 5; c++) begin
      rdc("mon_msb", 8'h60 + 8'(2 * c), mon_value[c][15:8]);
      rdc("mon_lsb", 8'h61 + 8'(2 * c), mon_value[c][7:0]);
    end
    // Negative temperature must flag low, which an unsigned compare would miss
    rdc("alarm_pri", `OFS_ALARM_PRI, 8'h62);
    rdc("alarm_rx", `OFS_ALARM_RX, 8'h40);
    rdc("warn_pri", `OFS_WARN_PRI, 8'h6A);
    rdc("warn_rx", `OFS_WARN_RX, 8'h40);
    // A value equal to its threshold is not a crossing
    @(posedge sys_clk);
    thr_alarm_hi <= {5{16'h2710}};
    mon_valid <= 1'b0;
    wt(3);
    rdc("alarm_pri", `OFS_ALARM_PRI, 8'h60);
    // Rate pins and soft rx bit still high from the last rate step
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'h39);
    $display("monitor test done");
    // Clock enable low: a write must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(`OFS_SOFT_CTRL, 8'h40);
    @(posedge sys_clk);
    ce <= 1'b1;
    rdc("soft_ctrl", `OFS_SOFT_CTRL, 8'h39);
    chk("outs", 8'h03, outs);
    $display("enable test done");
    close_out();
  end
endmodule // tb

// ---- src/transceiver_diag_control_map.sv ----
// Diagnostic and soft-control register area of a pluggable transceiver
// Behaviour
// - Temperature signed, 1/256 C per step
// - Supply voltage unsigned, 100 uV per step
// - Laser bias unsigned, 2 uA per step
// - Tx and rx power unsigned, 0.1 uW steps
// - Bytes 56..94 hold fixed calibration defaults
// - Byte 95 holds factory checksum
// - Bit 7 reads transmit-disable pin level
// - Soft inhibit ORed with disable pin
// - Soft receive rate bit, ORed with pin
// - Bit 2 mirrors transmit fault output
// - Bit 1 mirrors loss-of-signal output
// - Bit 0 low when monitor data valid
// - Soft commands act within 100 ms
// - Byte 112 primary alarm flag pairs
// - Byte 113 receive power alarm flags
// - Byte 116 primary warning flag pairs
// - Byte 117 receive power warning flags
// - Soft transmit rate bit, ORed with pin
// - High power class reads 0, request ignored
// - Rates selected independently per direction
// - Low rate only when pin and bit zero
// - Rate pin levels shown in bits 4, 5
`timescale 1ns/1ps
`include "xcvr_diag_consts.svh"

module transceiver_diag_control_map #(
  // Factory checksum over bytes 0..94
  parameter logic [7:0] CHECKSUM = 8'h00,
  // Default calibration byte content
  parameter logic [7:0] CAL_DEFAULT = 8'h00
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire xcvr_diag_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output xcvr_diag_pkg::byte_t reg_rdata,
  input wire logic tx_disable_pin,
  input wire logic rx_rate_pin,
  input wire logic tx_rate_pin,
  input wire logic tx_fault_int,
  input wire logic rx_los_int,
  input wire logic mon_valid,
  input wire xcvr_diag_pkg::mon_arr_t mon_value,
  input wire xcvr_diag_pkg::mon_arr_t thr_alarm_hi,
  input wire xcvr_diag_pkg::mon_arr_t thr_alarm_lo,
  input wire xcvr_diag_pkg::mon_arr_t thr_warn_hi,
  input wire xcvr_diag_pkg::mon_arr_t thr_warn_lo,
  output logic tx_disable,
  output logic tx_fault,
  output logic rx_los,
  output logic rx_rate_full,
  output logic tx_rate_full
);
  import xcvr_diag_pkg::*;

  // Soft command deadline in cycles, for reference checks
  localparam longint RESP_CYCLES = longint'(`CLK_HZ) / 1000 * `SOFT_RESP_MS;

  // Reset synchroniser stages
  logic rst_meta_q;
  logic rst_sync_n;

  // Release asynchronously asserted reset on the clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Pin synchroniser, first stage feeds only second stage
  logic [2:0] pin_meta_q;
  logic [2:0] pin_s_q;
  logic [2:0] pin_meta_d;
  logic [2:0] pin_s_d;

  // Next pin samples, held while ce is low
  always_comb begin
    pin_meta_d = pin_meta_q;
    pin_s_d = pin_s_q;
    if (ce) begin
      pin_meta_d = {tx_rate_pin, rx_rate_pin, tx_disable_pin};
      pin_s_d = pin_meta_q;
    end
  end

  // Register pin stages
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_s_q <= pin_s_d;
    end
  end

  // Synchronised pin levels
  logic txdis_pin_s;
  logic rx_rate_pin_s;
  logic tx_rate_pin_s;
  assign txdis_pin_s = pin_s_q[0];
  assign rx_rate_pin_s = pin_s_q[1];
  assign tx_rate_pin_s = pin_s_q[2];

  // Writable soft control bits and driven outputs
  logic soft_txdis_q;
  logic soft_txdis_d;
  logic soft_rx_rate_full_q;
  logic soft_rx_rate_full_d;
  logic soft_tx_rate_full_q;
  logic soft_tx_rate_full_d;
  logic [4:0] out_q;
  logic [4:0] out_d;
  logic wr_soft;
  logic wr_ext;

  // Write decode for the two control bytes
  assign wr_soft = ce && reg_wr && (reg_addr == `OFS_SOFT_CTRL);
  assign wr_ext = ce && reg_wr && (reg_addr == `OFS_EXT_CTRL);

  // Next control state; reserved and read-only bits drop writes
  always_comb begin
    soft_txdis_d = soft_txdis_q;
    soft_rx_rate_full_d = soft_rx_rate_full_q;
    soft_tx_rate_full_d = soft_tx_rate_full_q;
    out_d = out_q;
    // Writes land in one cycle, far inside the response time
    if (wr_soft) begin
      soft_txdis_d = reg_wdata[`SC_SOFT_TXDIS];
      soft_rx_rate_full_d = reg_wdata[`SC_SOFT_RX_RATE];
    end
    // Only the rate bit is kept; power request has no effect
    if (wr_ext) begin
      soft_tx_rate_full_d = reg_wdata[`EC_SOFT_TX_RATE];
    end
    if (ce) begin
      // Either source disables the transmitter
      out_d[0] = txdis_pin_s | soft_txdis_d;
      out_d[1] = tx_fault_int;
      out_d[2] = rx_los_int;
      // Each direction has its own pin and bit
      out_d[3] = rx_rate_pin_s | soft_rx_rate_full_d;
      out_d[4] = tx_rate_pin_s | soft_tx_rate_full_d;
    end
  end

  // Register control state; rates power up at low speed
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_txdis_q <= `RST_SOFT_TXDIS;
      soft_rx_rate_full_q <= `RST_SOFT_RATE;
      soft_tx_rate_full_q <= `RST_SOFT_RATE;
      out_q <= 5'h00;
    end else begin
      soft_txdis_q <= soft_txdis_d;
      soft_rx_rate_full_q <= soft_rx_rate_full_d;
      soft_tx_rate_full_q <= soft_tx_rate_full_d;
      out_q <= out_d;
    end
  end

  assign tx_disable = out_q[0];
  assign tx_fault = out_q[1];
  assign rx_los = out_q[2];
  assign rx_rate_full = out_q[3];
  assign tx_rate_full = out_q[4];

  // Threshold compare, signed only for temperature
  function automatic logic exceeds(input word_t a, input word_t b, input logic sgn);
    if (sgn) begin
      exceeds = $signed(a) > $signed(b);
    end else begin
      exceeds = a > b;
    end
  endfunction

  // Live flag vectors per channel
  logic [4:0] alm_hi_d;
  logic [4:0] alm_lo_d;
  logic [4:0] wrn_hi_d;
  logic [4:0] wrn_lo_d;
  logic [4:0] alm_hi_q;
  logic [4:0] alm_lo_q;
  logic [4:0] wrn_hi_q;
  logic [4:0] wrn_lo_q;
  mon_arr_t mon_q;
  mon_arr_t mon_d;
  logic ready_n_q;
  logic ready_n_d;

  // One comparator set per channel
  genvar c;
  generate
    for (c = 0; c < 5; c++) begin : g_chan
      localparam logic SGN = (c == 0) ? 1'b1 : 1'b0;
      always_comb begin
        alm_hi_d[c] = alm_hi_q[c];
        alm_lo_d[c] = alm_lo_q[c];
        wrn_hi_d[c] = wrn_hi_q[c];
        wrn_lo_d[c] = wrn_lo_q[c];
        mon_d[c] = mon_q[c];
        if (ce) begin
          // Flags follow the value, no latching
          alm_hi_d[c] = exceeds(mon_value[c], thr_alarm_hi[c], SGN);
          alm_lo_d[c] = exceeds(thr_alarm_lo[c], mon_value[c], SGN);
          wrn_hi_d[c] = exceeds(mon_value[c], thr_warn_hi[c], SGN);
          wrn_lo_d[c] = exceeds(thr_warn_lo[c], mon_value[c], SGN);
          // Words pass in their native encoding
          mon_d[c] = mon_value[c];
        end
      end
    end
  endgenerate

  // Readiness flag, low once monitor data is valid
  always_comb begin
    ready_n_d = ready_n_q;
    if (ce) begin
      ready_n_d = ~mon_valid;
    end
  end

  // Register flags and monitor snapshot
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alm_hi_q <= 5'h00;
      alm_lo_q <= 5'h00;
      wrn_hi_q <= 5'h00;
      wrn_lo_q <= 5'h00;
      mon_q <= '0;
      ready_n_q <= 1'b1;
    end else begin
      alm_hi_q <= alm_hi_d;
      alm_lo_q <= alm_lo_d;
      wrn_hi_q <= wrn_hi_d;
      wrn_lo_q <= wrn_lo_d;
      mon_q <= mon_d;
      ready_n_q <= ready_n_d;
    end
  end

  // Pack a primary flag byte, temperature pair on top
  function automatic byte_t pack_pri(input logic [4:0] hi, input logic [4:0] lo);
    pack_pri = {hi[0], lo[0], hi[1], lo[1], hi[2], lo[2], hi[3], lo[3]};
  endfunction

  // Read data, valid only the cycle after the strobe
  byte_t rdata_q;
  byte_t rdata_d;
  byte_t rsel;
  logic [3:0] mon_idx;

  // Byte select for the monitor block, MSB first
  assign mon_idx = 4'(reg_addr - `OFS_MON_FIRST);

  // Read mux; reserved bits and unmapped bytes give zero
  always_comb begin
    rsel = 8'h00;
    if (reg_addr >= `OFS_CAL_FIRST && reg_addr <= `OFS_CAL_LAST) begin
      rsel = CAL_DEFAULT;
    end else if (reg_addr >= `OFS_MON_FIRST && reg_addr <= `OFS_MON_LAST) begin
      rsel = mon_idx[0] ? mon_q[mon_idx[3:1]][7:0] : mon_q[mon_idx[3:1]][15:8];
    end else begin
      case (reg_addr)
        `OFS_CHECKSUM: begin
          rsel = CHECKSUM;
        end
        `OFS_SOFT_CTRL: begin
          rsel[`SC_TXDIS_PIN] = txdis_pin_s;
          rsel[`SC_SOFT_TXDIS] = soft_txdis_q;
          rsel[`SC_TX_RATE_PIN] = tx_rate_pin_s;
          rsel[`SC_RX_RATE_PIN] = rx_rate_pin_s;
          rsel[`SC_SOFT_RX_RATE] = soft_rx_rate_full_q;
          rsel[`SC_TX_FAULT] = tx_fault;
          rsel[`SC_RX_LOS] = rx_los;
          rsel[`SC_READY_N] = ready_n_q;
        end
        `OFS_ALARM_PRI: begin
          rsel = pack_pri(alm_hi_q, alm_lo_q);
        end
        `OFS_ALARM_RX: begin
          rsel = {alm_hi_q[4], alm_lo_q[4], 6'h00};
        end
        `OFS_WARN_PRI: begin
          rsel = pack_pri(wrn_hi_q, wrn_lo_q);
        end
        `OFS_WARN_RX: begin
          rsel = {wrn_hi_q[4], wrn_lo_q[4], 6'h00};
        end
        `OFS_EXT_CTRL: begin
          // High power class never active
          rsel[`EC_SOFT_TX_RATE] = soft_tx_rate_full_q;
        end
        default: begin
          rsel = 8'h00;
        end
      endcase
    end
  end

  // Capture on read strobe, otherwise return to zero; hold while ce is low
  always_comb begin
    rdata_d = rdata_q;
    if (ce) begin
      rdata_d = reg_rd ? rsel : 8'h00;
    end
  end

  // Register read data
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks, all on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_soft_txdis;
    (wr_soft && reg_wdata[`SC_SOFT_TXDIS]) |=> tx_disable;
  endproperty
  a_soft_txdis: assert property (p_soft_txdis) else $error("soft inhibit ignored");

  property p_rx_rate;
    (wr_soft && reg_wdata[`SC_SOFT_RX_RATE]) |=> rx_rate_full;
  endproperty
  a_rx_rate: assert property (p_rx_rate) else $error("rx rate bit ignored");

  property p_tx_rate;
    (wr_ext && reg_wdata[`EC_SOFT_TX_RATE]) |=> tx_rate_full;
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("tx rate bit ignored");

  property p_low_rate;
    (ce && !rx_rate_pin_s && !soft_rx_rate_full_d) |=> !rx_rate_full;
  endproperty
  a_low_rate: assert property (p_low_rate) else $error("rx not at low rate");

  property p_ext_read;
    (ce && reg_rd && reg_addr == `OFS_EXT_CTRL) |=>
      (reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0 &&
       reg_rdata[3] == $past(soft_tx_rate_full_q));
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("ext control readback wrong");

  property p_ctrl_read;
    (ce && reg_rd && reg_addr == `OFS_SOFT_CTRL) |=>
      (reg_rdata[7] == $past(txdis_pin_s) && reg_rdata[2] == $past(tx_fault) &&
       reg_rdata[1] == $past(rx_los) && reg_rdata[0] == $past(ready_n_q));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("soft control readback wrong");

  property p_pin_read;
    (ce && reg_rd && reg_addr == `OFS_SOFT_CTRL) |=>
      (reg_rdata[5:4] == $past({tx_rate_pin_s, rx_rate_pin_s}));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("rate pins not reflected");

  property p_checksum;
    (ce && reg_rd && reg_addr == `OFS_CHECKSUM) |=> reg_rdata == CHECKSUM;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum byte wrong");

  property p_rx_flag_rsvd;
    (ce && reg_rd && (reg_addr == `OFS_ALARM_RX || reg_addr == `OFS_WARN_RX)) |=>
      reg_rdata[5:0] == 6'h00;
  endproperty
  a_rx_flag_rsvd: assert property (p_rx_flag_rsvd) else $error("reserved flag bits set");

  property p_temp_msb;
    (ce && reg_rd && reg_addr == `OFS_MON_FIRST) |=> reg_rdata == $past(mon_q[0][15:8]);
  endproperty
  a_temp_msb: assert property (p_temp_msb) else $error("temperature MSB wrong");

  property p_no_strobe;
    (ce && !reg_rd) |=> reg_rdata == 8'h00;
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("read data outside slot");

endmodule // transceiver_diag_control_map

// ---- src/xcvr_diag_consts.svh ----
// Offsets, bit positions, reset values and timing for the diagnostic control map
`ifndef XCVR_DIAG_CONSTS_SVH
`define XCVR_DIAG_CONSTS_SVH

// Byte offsets in the diagnostic page
`define OFS_CAL_FIRST 8'h38
`define OFS_CAL_LAST 8'h5E
`define OFS_CHECKSUM 8'h5F
`define OFS_MON_FIRST 8'h60
`define OFS_MON_LAST 8'h69
`define OFS_SOFT_CTRL 8'h6E
`define OFS_ALARM_PRI 8'h70
`define OFS_ALARM_RX 8'h71
`define OFS_WARN_PRI 8'h74
`define OFS_WARN_RX 8'h75
`define OFS_EXT_CTRL 8'h76

// Soft control byte fields
`define SC_TXDIS_PIN 7
`define SC_SOFT_TXDIS 6
`define SC_TX_RATE_PIN 5
`define SC_RX_RATE_PIN 4
`define SC_SOFT_RX_RATE 3
`define SC_TX_FAULT 2
`define SC_RX_LOS 1
`define SC_READY_N 0

// Extended control byte fields
`define EC_SOFT_TX_RATE 3
`define EC_HIGH_POWER 1
`define EC_POWER_REQ 0

// Reset values of writable bits
`define RST_SOFT_TXDIS 1'b0
`define RST_SOFT_RATE 1'b0

// Soft command response time
`define SOFT_RESP_MS 100
`define CLK_HZ 40000000

`endif

// ---- src/xcvr_diag_pkg.sv ----
// Types shared by the diagnostic control map
package xcvr_diag_pkg;
  // One management byte
  typedef logic [7:0] byte_t;
  // One 16-bit monitor or threshold word
  typedef logic [15:0] word_t;
  // Five monitor channels, index is the channel
  typedef logic [4:0][15:0] mon_arr_t;
  // Monitor channel order
  typedef enum logic [2:0] {
    CH_TEMP = 3'b000,
    CH_VCC = 3'b001,
    CH_BIAS = 3'b010,
    CH_TXPWR = 3'b011,
    CH_RXPWR = 3'b100
  } mon_chan_t;
endpackage
